/* File: src/vow_pkg.sv */
// constants for the voltage-code override block with its watchdog
// assumes a 100 MHz mclk and an AHB-Lite master with word-aligned single transfers
package vow_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG   = 8'h00;
  localparam logic [7:0] IDX_OFS   = 8'h01;
  localparam logic [7:0] IDX_MAN   = 8'h02;
  localparam logic [7:0] IDX_KEY   = 8'h03;
  localparam logic [7:0] IDX_PIN   = 8'h04;
  localparam logic [7:0] IDX_WCFG  = 8'h05;
  localparam logic [7:0] IDX_WTIME = 8'h06;
  localparam logic [7:0] IDX_OVC   = 8'h07;
  localparam logic [7:0] IDX_EN    = 8'h30;
  localparam logic [7:0] IDX_IRQS  = 8'h40;
  localparam logic [7:0] IDX_IRQM  = 8'h41;
  localparam logic [7:0] IDX_BHI   = 8'h60;
  localparam logic [7:0] IDX_BLO   = 8'h61;
  // field positions
  localparam int CFG_OUTEN  = 7;
  localparam int CFG_OTF    = 2;
  localparam int MAN_MODE   = 7;
  localparam int MAN_KEYOK  = 6;
  localparam int WCFG_FLAG  = 6;
  localparam int WCFG_EN    = 5;
  localparam int WCFG_PULSE = 4;
  localparam int WCFG_UNIT  = 3;
  localparam int WCFG_POL   = 2;
  localparam int OVC_SEL    = 5;
  localparam int IRQ_TMO    = 0;
  localparam int IRQ_SLOT   = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IRQ  = 2'h0;
  // key value is arbitrary
  localparam logic [7:0] KEY_DEFAULT = 8'hA5;
  // timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int HZ_PER_KHZ = 1000;
  localparam int MS_CYCLES  = CLK_HZ / HZ_PER_KHZ;
  localparam int MS_PER_S   = 1000;
  localparam int S_PER_MIN  = 60;
  localparam int PW0_MS     = 1;
  localparam int PW1_MS     = 25;
  localparam int PW2_MS     = 125;
  localparam int PW3_S      = 5;
  localparam int PRE_W      = 17;
  localparam int MS_W       = 16;
endpackage

/* File: src/vow_top.sv */
// voltage-code override block with watchdog, as an AHB-Lite register slave
// assumes one master, single word transfers, pins asynchronous to mclk
// What this block does
// - enable bit 0 turns code logic on
// - base address bytes at 60h, 61h, reset 00h
// - timeout drives reset pin only when enabled
// - on-the-fly bit cleared by slot or timeout
// - signed four-bit offset shifts input code
// - manual mode without on-the-fly presents manual value
// - key-ok bit set by correct key write
// - pin register returns synchronised input code
// - timeout flag set by timeout, one clears
// - watchdog counts only while count enable set
// - pulse select chooses level or pulse output
// - unit select picks one or sixty seconds
// - polarity select makes output high or low active
// - pulse width 1, 25, 125 ms or 5 s
// - eight-bit watchdog time in units, reset zero
// - register clear source: power loss or slot
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module vow_top #(
  parameter int MS_CYCLES = vow_pkg::MS_CYCLES,
  parameter int MS_PER_S  = vow_pkg::MS_PER_S,
  parameter logic [7:0] KEY_VALUE = vow_pkg::KEY_DEFAULT
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins
  input  wire logic [3:0]  code_inputs,
  input  wire logic        slot_occupied_n,
  input  wire logic        main_power_ok,
  output logic [3:0]       code_outputs,
  output logic             timeout_reset_pin_n,
  output logic             system_reset_out,
  output logic             irq
);
  typedef struct packed {
    logic [3:0]  in_s1;
    logic [3:0]  in_s2;
    logic        slot_s1;
    logic        slot_s2;
    logic        slot_d;
    logic        pwr_s1;
    logic        pwr_s2;
    logic        vid_en;
    logic [7:0]  bhi;
    logic [7:0]  blo;
    logic        timeout_reset_out_enable;
    logic        on_the_fly_enable;
    logic [1:0]  cfg_dummy;
    logic [3:0]  offset;
    logic        man_mode;
    logic [3:0]  man_val;
    logic        key_ok;
    logic [7:0]  key;
    logic        wflag;
    logic        wen;
    logic        wpulse;
    logic        wunit;
    logic        wpol;
    logic [1:0]  pw;
    logic [7:0]  wtime;
    logic [7:0]  ovc;
    logic [1:0]  ists;
    logic [1:0]  imask;
    logic [vow_pkg::PRE_W-1:0] pre;
    logic [vow_pkg::MS_W-1:0]  msc;
    logic [7:0]  elapsed;
    logic [vow_pkg::PRE_W-1:0] ppre;
    logic [vow_pkg::MS_W-1:0]  pcnt;
    logic        pulse_on;
    logic        level_on;
    logic        ap_ok;
    logic        ap_wr;
    logic [7:0]  ap_idx;
    logic [3:0]  code;
    logic        rst_pin_n;
    logic        sys_out;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
  } vow_state_t;

  vow_state_t s;
  vow_state_t n;

  // input code plus signed offset, clamped to the code range
  function automatic logic [3:0] vow_shift(input logic [3:0] code, input logic [3:0] ofs);
    logic signed [5:0] t;
    t = $signed({2'b00, code}) + $signed({{2{ofs[3]}}, ofs});
    if (t < 6'sd0) begin
      vow_shift = 4'h0;
    end else if (t > 6'sd15) begin
      vow_shift = 4'hF;
    end else begin
      vow_shift = t[3:0];
    end
  endfunction

  function automatic logic [vow_pkg::MS_W-1:0] vow_width_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    vow_width_ms = vow_pkg::MS_W'(vow_pkg::PW0_MS);
      2'h1:    vow_width_ms = vow_pkg::MS_W'(vow_pkg::PW1_MS);
      2'h2:    vow_width_ms = vow_pkg::MS_W'(vow_pkg::PW2_MS);
      default: vow_width_ms = vow_pkg::MS_W'(vow_pkg::PW3_S * MS_PER_S);
    endcase
  endfunction

  logic                      tick_ms;
  logic                      tick_unit;
  logic                      tmo;
  logic                      slot_act;
  logic                      clr_vid;
  logic                      wr;
  logic [7:0]                d;
  logic [vow_pkg::MS_W-1:0]  unit_ms;

  always_comb begin
    n         = s;
    tick_ms   = 1'b0;
    tick_unit = 1'b0;
    tmo       = 1'b0;
    wr        = s.ap_ok & s.ap_wr;
    d         = hwdata[7:0];
    // two-stage synchronisers
    n.in_s1   = code_inputs;
    n.in_s2   = s.in_s1;
    n.slot_s1 = slot_occupied_n;
    n.slot_s2 = s.slot_s1;
    n.slot_d  = s.slot_s2;
    n.pwr_s1  = main_power_ok;
    n.pwr_s2  = s.pwr_s1;
    slot_act  = ~s.slot_s2;
    unit_ms   = s.wunit ? vow_pkg::MS_W'(MS_PER_S * vow_pkg::S_PER_MIN)
                        : vow_pkg::MS_W'(MS_PER_S);

    // register writes in the data phase
    if (wr) begin
      case (s.ap_idx)
        vow_pkg::IDX_EN:  n.vid_en = d[0];
        vow_pkg::IDX_BHI: n.bhi = d;
        vow_pkg::IDX_BLO: n.blo = d;
        vow_pkg::IDX_CFG: begin
          n.timeout_reset_out_enable  = d[vow_pkg::CFG_OUTEN];
          n.on_the_fly_enable    = d[vow_pkg::CFG_OTF];
          n.cfg_dummy = d[1:0];
        end
        vow_pkg::IDX_OFS: n.offset = d[3:0];
        vow_pkg::IDX_MAN: begin
          // manual mode can only be entered once the key is in
          n.man_mode = d[vow_pkg::MAN_MODE] & s.key_ok;
          n.man_val  = d[3:0];
        end
        vow_pkg::IDX_KEY: begin
          n.key    = d;
          n.key_ok = (d == KEY_VALUE);
        end
        vow_pkg::IDX_WCFG: begin
          n.wflag  = s.wflag & ~d[vow_pkg::WCFG_FLAG];
          n.wen    = d[vow_pkg::WCFG_EN];
          n.wpulse = d[vow_pkg::WCFG_PULSE];
          n.wunit  = d[vow_pkg::WCFG_UNIT];
          n.wpol   = d[vow_pkg::WCFG_POL];
          n.pw     = d[1:0];
        end
        vow_pkg::IDX_WTIME: begin
          // a new time restarts the count
          n.wtime   = d;
          n.elapsed = 8'h00;
          n.msc     = '0;
          n.pre     = '0;
        end
        vow_pkg::IDX_OVC:  n.ovc = d;
        vow_pkg::IDX_IRQS: n.ists = s.ists & ~d[1:0];
        vow_pkg::IDX_IRQM: n.imask = d[1:0];
        default: ;
      endcase
    end

    // watchdog: the prescaler only runs while counting so every unit is whole, except the first after a new time written while counting
    if (s.wen) begin
      if (s.pre == vow_pkg::PRE_W'(MS_CYCLES - 1)) begin
        n.pre   = '0;
        tick_ms = 1'b1;
      end else begin
        n.pre = s.pre + 1'b1;
      end
      if (tick_ms) begin
        if (s.msc == unit_ms - 1'b1) begin
          n.msc     = '0;
          tick_unit = 1'b1;
        end else begin
          n.msc = s.msc + 1'b1;
        end
      end
      if (tick_unit) begin
        if (s.elapsed + 8'h01 == s.wtime) begin
          tmo       = 1'b1;
          n.elapsed = 8'h00;
        end else begin
          n.elapsed = s.elapsed + 8'h01;
        end
      end
    end else begin
      n.pre = '0;
      n.msc = '0;
    end

    // pulse width timing has its own prescaler so the width is exact
    if (s.pulse_on) begin
      if (s.ppre == vow_pkg::PRE_W'(MS_CYCLES - 1)) begin
        n.ppre = '0;
        if (s.pcnt == vow_width_ms(s.pw) - 1'b1) begin
          n.pulse_on = 1'b0;
        end else begin
          n.pcnt = s.pcnt + 1'b1;
        end
      end else begin
        n.ppre = s.ppre + 1'b1;
      end
    end

    // events: a set beats a clear in the same cycle
    if (tmo) begin
      n.wflag          = 1'b1;
      n.ists[vow_pkg::IRQ_TMO] = 1'b1;
      if (s.timeout_reset_out_enable) begin
        if (s.wpulse) begin
          n.pulse_on = 1'b1;
          n.ppre     = '0;
          n.pcnt     = '0;
        end else begin
          n.level_on = 1'b1;
        end
      end
    end
    if (s.slot_d & ~s.slot_s2) begin
      n.ists[vow_pkg::IRQ_SLOT] = 1'b1;
    end
    // a level reset holds until software clears the timeout flag
    n.level_on = n.level_on & n.wflag;

    // hardware clears of the code registers
    clr_vid = tmo | (s.ovc[vow_pkg::OVC_SEL] ? slot_act : ~s.pwr_s2);
    if (clr_vid) begin
      n.timeout_reset_out_enable  = 1'b0;
      n.cfg_dummy = 2'h0;
      n.offset    = 4'h0;
      n.man_mode  = 1'b0;
      n.man_val   = 4'h0;
      n.ovc       = vow_pkg::RST_BYTE;
    end
    if (tmo | slot_act) begin
      n.on_the_fly_enable = 1'b0;
    end

    // address phase; reads see this cycle's write and events
    if (hsel & hready & htrans[1]) begin
      n.ap_ok  = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
      n.ap_wr  = hwrite;
      n.ap_idx = haddr[9:2];
      n.rdata  = 32'h0;
      if (~hwrite) begin
        case (haddr[9:2])
          vow_pkg::IDX_EN:    n.rdata[0] = n.vid_en;
          vow_pkg::IDX_BHI:   n.rdata[7:0] = n.bhi;
          vow_pkg::IDX_BLO:   n.rdata[7:0] = n.blo;
          vow_pkg::IDX_CFG:   n.rdata[7:0] = {n.timeout_reset_out_enable, 4'h0, n.on_the_fly_enable, n.cfg_dummy};
          vow_pkg::IDX_OFS:   n.rdata[3:0] = n.offset;
          vow_pkg::IDX_MAN:   n.rdata[7:0] = {n.man_mode, n.key_ok, 2'h0, n.man_val};
          vow_pkg::IDX_KEY:   n.rdata[7:0] = n.key;
          vow_pkg::IDX_PIN:   n.rdata[3:0] = s.in_s2;
          vow_pkg::IDX_WCFG:  n.rdata[7:0] = {1'b0, n.wflag, n.wen, n.wpulse,
                                              n.wunit, n.wpol, n.pw};
          vow_pkg::IDX_WTIME: n.rdata[7:0] = n.wtime;
          vow_pkg::IDX_OVC:   n.rdata[7:0] = n.ovc;
          vow_pkg::IDX_IRQS:  n.rdata[1:0] = n.ists;
          vow_pkg::IDX_IRQM:  n.rdata[1:0] = n.imask;
          default:            n.rdata = 32'h0;
        endcase
        if (~n.ap_ok) begin
          n.rdata = 32'h0;
        end
      end
    end else if (hready) begin
      n.ap_ok = 1'b0;
      n.ap_wr = 1'b0;
    end

    // outputs, registered from the next state
    if (~n.vid_en) begin
      n.code = s.in_s2;
    end else if (n.man_mode & ~n.on_the_fly_enable) begin
      n.code = n.man_val;
    end else begin
      n.code = vow_shift(s.in_s2, n.offset);
    end
    n.rst_pin_n = ~(n.level_on | n.pulse_on);
    n.sys_out   = (n.level_on | n.pulse_on) ? n.wpol : ~n.wpol;
    n.irq       = |(n.ists & n.imask);
    n.ready     = 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s           <= '0;
      s.slot_s1   <= 1'b1;
      s.slot_s2   <= 1'b1;
      s.slot_d    <= 1'b1;
      s.pwr_s1    <= 1'b1;
      s.pwr_s2    <= 1'b1;
      s.rst_pin_n <= 1'b1;
      s.sys_out   <= 1'b1;
      s.ready     <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout           = s.ready;
  assign hresp               = 1'b0;
  assign hrdata              = s.rdata;
  assign code_outputs        = s.code;
  assign timeout_reset_pin_n = s.rst_pin_n;
  assign system_reset_out    = s.sys_out;
  assign irq                 = s.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  flag_set_a: assert property (tmo |=> s.wflag)
    else $error("timeout did not set flag");
  flag_clear_a: assert property (
    wr && s.ap_idx == vow_pkg::IDX_WCFG && d[vow_pkg::WCFG_FLAG] && !tmo |=> !s.wflag)
    else $error("flag not cleared by one");
  out_gate_a: assert property (
    $rose(s.level_on | s.pulse_on) |-> $past(s.timeout_reset_out_enable))
    else $error("reset asserted while disabled");
  otf_clear_a: assert property ((tmo || slot_act) |=> !s.on_the_fly_enable)
    else $error("on-the-fly bit survived clear");
  manual_out_a: assert property (
    s.vid_en && s.man_mode && !s.on_the_fly_enable |-> s.code == s.man_val)
    else $error("manual value not presented");
  key_check_a: assert property (
    wr && s.ap_idx == vow_pkg::IDX_KEY && d != KEY_VALUE |=> !s.key_ok)
    else $error("key ok after wrong key");
  count_stop_a: assert property (!s.wen |=> !tmo ##0 s.pre == '0)
    else $error("watchdog counted while off");
  polarity_out_a: assert property (
    !s.level_on && !s.pulse_on |-> s.sys_out != s.wpol)
    else $error("idle output has wrong polarity");
  level_hold_a: assert property (
    s.level_on && s.wflag && !wr |=> s.level_on)
    else $error("level reset dropped early");
  vid_clear_a: assert property (tmo |=> s.offset == 4'h0 && !s.man_mode)
    else $error("code registers kept after timeout");
  irq_level_a: assert property (s.irq == |(s.ists & s.imask))
    else $error("interrupt does not follow status");

  tmo_c: cover property (tmo);
  pulse_c: cover property ($fell(s.pulse_on));
  manual_c: cover property (s.vid_en && s.man_mode && !s.on_the_fly_enable);
endmodule

/* File: verification/vow_vr.sv */
// regulator-side model: drives the code input pins and records the applied code
// assumes mclk from the bench; pins change just after a rising edge
`timescale 1ns/1ps
module vow_vr (
  // clock
  input  wire logic       mclk,
  // pins
  input  wire logic [3:0] code_outputs,
  input  wire logic [3:0] want_code,
  output logic [3:0]      code_inputs,
  output logic [3:0]      applied
);
  initial code_inputs = 4'h0;
  initial applied = 4'h0;
  // pins move only after an edge so the block's synchroniser sees clean steps
  always @(posedge mclk) begin
    code_inputs <= want_code;
    applied     <= code_outputs;
  end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the voltage-code block with its watchdog
// assumes the regulator model on the code pins and zero-wait bus answers
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [31:0] e; logic [31:0] m;} vow_note_t;
  localparam int MSC  = 4;
  localparam int MPS  = 3;
  localparam int UNIT = MSC * MPS;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        slot_n = 1'b1;
  logic        pwr_ok = 1'b1;
  logic [3:0]  want_code = 4'h0;
  logic        hreadyout, hresp, pin_n, sro, irq;
  logic [31:0] hrdata, got, rdat, r;
  logic [3:0]  code_inputs, code_outputs;
  int          n, n_mismatch, comparisons;
  vow_note_t   q[$];
  event        res_ev;
  logic [7:0]  regs [12] = '{vow_pkg::IDX_CFG, vow_pkg::IDX_OFS, vow_pkg::IDX_MAN,
    vow_pkg::IDX_KEY, vow_pkg::IDX_WCFG, vow_pkg::IDX_WTIME, vow_pkg::IDX_OVC,
    vow_pkg::IDX_EN, vow_pkg::IDX_IRQS, vow_pkg::IDX_IRQM, vow_pkg::IDX_BHI, vow_pkg::IDX_BLO};
  // pin code, signed offset, resulting clamped code
  logic [11:0] ct [4] = '{12'h538, 12'h5E3, 12'h1C0, 12'hE3F};
  int          pw [4] = '{1, 25, 125, 5 * MPS};

  always #5 mclk = ~mclk;

  vow_top #(.MS_CYCLES(MSC), .MS_PER_S(MPS)) vow_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .code_inputs(code_inputs),
    .slot_occupied_n(slot_n), .main_power_ok(pwr_ok), .code_outputs(code_outputs),
    .timeout_reset_pin_n(pin_n), .system_reset_out(sro), .irq(irq));

  vow_vr vow_vr_inst (.mclk(mclk), .code_outputs(code_outputs), .want_code(want_code),
    .code_inputs(code_inputs), .applied());

  // watcher: every posted result is matched against the oldest note
  initial begin
    vow_note_t it;
    forever begin
      @(res_ev);
      it = q.pop_front();
      comparisons++;
      if ((got & it.m) !== (it.e & it.m)) begin
        n_mismatch++;
        $display("unexpected at %0t: got %h want %h", $time, got, it.e);
      end
    end
  end

  task automatic post(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    q.push_back('{e, m});
    got = g;
    -> res_ev;
    #1;
  endtask

  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    bus(idx, 1'b0, 8'h00);
    post({24'h0, e}, 32'hFFFFFFFF, rdat);
  endtask

  // outputs packed as {response, reset out, reset pin, irq, code}, looked at mid-cycle;
  // the bus response must read OKAY on every look
  task automatic out(input logic [6:0] e, input logic [6:0] m);
    @(negedge mclk);
    post({24'h0, 1'b0, e}, {24'h0, 1'b1, m}, {24'h0, hresp, sro, pin_n, irq, code_outputs});
  endtask

  task automatic rng(input int lo, input int hi);
    post(32'h1, 32'h1, {31'h0, (n >= lo && n <= hi)});
  endtask

  task automatic fin(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done;
    @(negedge mclk);
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    test_done();
  end

  initial begin
    r = $urandom(67);
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'hFF, 8'h00);
    fin("reset");
    r = $urandom;
    wr(vow_pkg::IDX_BHI, r[7:0]);
    rd(vow_pkg::IDX_BHI, r[7:0]);
    wr(vow_pkg::IDX_BLO, r[15:8]);
    rd(vow_pkg::IDX_BLO, r[15:8]);
    wr(vow_pkg::IDX_WTIME, r[23:16]);
    rd(vow_pkg::IDX_WTIME, r[23:16]);
    wr(vow_pkg::IDX_EN, 8'hFE);
    rd(vow_pkg::IDX_EN, 8'h00);
    wr(vow_pkg::IDX_OFS, 8'hF0);
    rd(vow_pkg::IDX_OFS, 8'h00);
    want_code <= r[27:24];
    repeat (5) @(posedge mclk);
    rd(vow_pkg::IDX_PIN, {4'h0, r[27:24]});
    out({3'h0, r[27:24]}, 7'h0F);
    fin("registers");
    wr(vow_pkg::IDX_EN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      want_code <= ct[i][11:8];
      wr(vow_pkg::IDX_OFS, {4'h0, ct[i][7:4]});
      repeat (4) @(posedge mclk);
      out({3'h0, ct[i][3:0]}, 7'h0F);
    end
    fin("offset");
    // a wrong key leaves manual mode locked out; the value still lands
    wr(vow_pkg::IDX_KEY, ~vow_pkg::KEY_DEFAULT);
    wr(vow_pkg::IDX_MAN, 8'h8A);
    rd(vow_pkg::IDX_MAN, 8'h0A);
    wr(vow_pkg::IDX_KEY, vow_pkg::KEY_DEFAULT);
    rd(vow_pkg::IDX_MAN, 8'h4A);
    wr(vow_pkg::IDX_MAN, 8'h8A);
    out(7'h0A, 7'h0F);
    wr(vow_pkg::IDX_CFG, 8'h84);
    out(7'h0F, 7'h0F);
    fin("manual");
    want_code <= 4'h6;
    wr(vow_pkg::IDX_IRQM, 8'h01);
    wr(vow_pkg::IDX_WCFG, 8'h24);
    wr(vow_pkg::IDX_WTIME, 8'h02);
    // wait loops look mid-cycle, so an output launched by the last edge is settled
    n = 0;
    while (pin_n !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    rng(2 * UNIT - 3, 2 * UNIT + 4);
    out(7'h56, 7'h7F);
    rd(vow_pkg::IDX_WCFG, 8'h64);
    rd(vow_pkg::IDX_CFG, 8'h00);
    wr(vow_pkg::IDX_WCFG, 8'h04);
    rd(vow_pkg::IDX_WCFG, 8'h44);
    out(7'h56, 7'h7F);
    wr(vow_pkg::IDX_WCFG, 8'h44);
    wr(vow_pkg::IDX_IRQS, 8'h01);
    out(7'h26, 7'h7F);
    fin("level timeout");
    for (int k = 0; k < 4; k++) begin
      wr(vow_pkg::IDX_CFG, 8'h80);
      wr(vow_pkg::IDX_WTIME, 8'd50);
      wr(vow_pkg::IDX_WCFG, 8'h30 | k[7:0]);
      // let the new polarity settle before looking for the pulse
      @(negedge mclk);
      n = 0;
      while (sro !== 1'b0 && n < 700) begin
        @(negedge mclk);
        n++;
      end
      n = 0;
      while (sro === 1'b0 && n < 700) begin
        @(negedge mclk);
        n++;
      end
      rng(pw[k] * MSC - 1, pw[k] * MSC + 3);
      wr(vow_pkg::IDX_WCFG, 8'h40);
      wr(vow_pkg::IDX_IRQS, 8'h01);
    end
    fin("pulse widths");
    wr(vow_pkg::IDX_WTIME, 8'h01);
    wr(vow_pkg::IDX_WCFG, 8'h28);
    n = 0;
    while (irq !== 1'b1 && n < 900) begin
      @(negedge mclk);
      n++;
    end
    rng(60 * UNIT - 4, 60 * UNIT + 4);
    out(7'h70, 7'h70);
    wr(vow_pkg::IDX_WCFG, 8'h40);
    wr(vow_pkg::IDX_IRQS, 8'h01);
    fin("minute unit");
    wr(vow_pkg::IDX_OFS, 8'h03);
    pwr_ok <= 1'b0;
    repeat (4) @(posedge mclk);
    pwr_ok <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(vow_pkg::IDX_OFS, 8'h00);
    wr(vow_pkg::IDX_OVC, 8'h20);
    wr(vow_pkg::IDX_OFS, 8'h03);
    slot_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(vow_pkg::IDX_OFS, 8'h00);
    slot_n <= 1'b1;
    rd(vow_pkg::IDX_IRQS, 8'h02);
    fin("clear source");
    test_done();
  end
endmodule
